// File: include/cec_pkg.sv
// Constants for the comparator edge-control block.
// Assumes one 8-bit register reached by a byte-wide register port.
package cec_pkg;

    // Register port widths
    localparam int CEC_ADDR_W = 8;
    localparam int CEC_DATA_W = 8;

    // Control and status register address
    localparam logic [CEC_ADDR_W-1:0] CEC_CTRL_ADDR = 8'hBF;
    // Reset value of the whole register
    localparam logic [CEC_DATA_W-1:0] CEC_CTRL_RESET = 8'h00;

    // Field positions
    localparam int CEC_BIT_ENABLE = 7;
    localparam int CEC_BIT_RESULT = 6;
    localparam int CEC_BIT_RISE = 5;
    localparam int CEC_BIT_FALL = 4;
    localparam int CEC_POS_HYS_LSB = 2;
    localparam int CEC_NEG_HYS_LSB = 0;
    localparam int CEC_HYS_W = 2;

    // Hysteresis selection codes, shared by both directions
    localparam logic [CEC_HYS_W-1:0] CEC_HYS_OFF = 2'h0;
    localparam logic [CEC_HYS_W-1:0] CEC_HYS_5MV = 2'h1;
    localparam logic [CEC_HYS_W-1:0] CEC_HYS_10MV = 2'h2;
    localparam logic [CEC_HYS_W-1:0] CEC_HYS_20MV = 2'h3;

    // Number of flip-flops in each synchroniser
    localparam int CEC_SYNC_STAGES = 2;

endpackage

// File: verilog/cec_sync.sv
// Two-stage level synchroniser used for the raw comparator output
// and for the reset release.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/1ps
module cec_sync (
    input wire logic clk_i, // Sampling clock
    input wire logic rst_n_i, // Asynchronous clear, active low
    input wire logic d_i, // Asynchronous level in
    output logic q_o // Synchronised level out
);
    // First stage is read only by the second stage
    logic meta_q;

    // Plain two-flop chain, cleared to zero under reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// File: verilog/cec_top.sv
// Control and status logic for one analog voltage comparator.
// Assumes the analog core drives raw_compare_i asynchronously and
// software uses the byte-wide register port on mclk_i.
//
// Functional notes
// - Enable bit, 0 off, 1 on, resets 0
// - Read-only result: 0 when plus below minus
// - Rising edge sets sticky flag, software clears
// - Falling edge sets sticky flag, software clears
// - Two-bit positive hysteresis select, resets 00
// - Two-bit negative hysteresis select, same codes
// - Flag reads 1 only after an edge or a software write of 1
`timescale 1ns/1ps
module cec_top (
    input wire logic mclk_i, // System clock, 40 MHz
    input wire logic resetn_i, // Asynchronous reset, active low
    input wire logic [cec_pkg::CEC_ADDR_W-1:0] reg_addr_i, // Reg address
    input wire logic reg_wr_i, // Write strobe, one cycle
    input wire logic reg_rd_i, // Read strobe, one cycle
    input wire logic [cec_pkg::CEC_DATA_W-1:0] reg_wdata_i, // Write data
    output logic [cec_pkg::CEC_DATA_W-1:0] reg_rdata_o, // Read data
    input wire logic raw_compare_i, // Raw analog compare output
    output logic comparator_enable_o, // Enable to analog core
    output logic [cec_pkg::CEC_HYS_W-1:0] positive_hysteresis_select_o, // Pos
    output logic [cec_pkg::CEC_HYS_W-1:0] negative_hysteresis_select_o // Neg
);
    import cec_pkg::*;

    // Synchronised reset
    logic rst_n;
    // Raw compare after the synchroniser
    logic raw_sync;
    // Previous synchronised sample, for edge detection
    logic raw_prev_q;
    // Stored register fields
    logic comparator_enable_q;
    logic compare_result_q;
    logic rising_edge_flag_q;
    logic falling_edge_flag_q;
    logic [CEC_HYS_W-1:0] pos_hys_q;
    logic [CEC_HYS_W-1:0] negative_hysteresis_select_q;
    // Read data register
    logic [CEC_DATA_W-1:0] rdata_q;
    // Decoded accesses and edge events
    logic wr_hit;
    logic rd_hit;
    logic rise_evt;
    logic fall_evt;

    // Address match, used for both read and write
    function automatic logic addr_hit(input logic [CEC_ADDR_W-1:0] a);
        return a == CEC_CTRL_ADDR;
    endfunction

    // Reset release through two flip-flops
    cec_sync u_rst_sync (
        .clk_i(mclk_i),
        .rst_n_i(resetn_i),
        .d_i(1'b1),
        .q_o(rst_n)
    );

    // Bring the analog output into the clock domain
    cec_sync u_cmp_sync (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .d_i(raw_compare_i),
        .q_o(raw_sync)
    );

    // Access decode
    assign wr_hit = reg_wr_i && addr_hit(reg_addr_i);
    assign rd_hit = reg_rd_i && addr_hit(reg_addr_i);

    // Edges seen only while the comparator is enabled
    assign rise_evt = comparator_enable_q && raw_sync && !raw_prev_q;
    assign fall_evt = comparator_enable_q && !raw_sync && raw_prev_q;

    // Enable bit
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            comparator_enable_q <= CEC_CTRL_RESET[CEC_BIT_ENABLE];
        end else if (wr_hit) begin
            comparator_enable_q <= reg_wdata_i[CEC_BIT_ENABLE];
        end
    end

    // Hysteresis selections
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pos_hys_q <= CEC_CTRL_RESET[CEC_POS_HYS_LSB +: CEC_HYS_W];
            negative_hysteresis_select_q <=
                CEC_CTRL_RESET[CEC_NEG_HYS_LSB +: CEC_HYS_W];
        end else if (wr_hit) begin
            pos_hys_q <= reg_wdata_i[CEC_POS_HYS_LSB +: CEC_HYS_W];
            negative_hysteresis_select_q <=
                reg_wdata_i[CEC_NEG_HYS_LSB +: CEC_HYS_W];
        end
    end

    // Edge history always follows the synchronised level
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            raw_prev_q <= 1'b0;
        end else begin
            raw_prev_q <= raw_sync;
        end
    end

    // Live result, forced to 0 while disabled
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            compare_result_q <= CEC_CTRL_RESET[CEC_BIT_RESULT];
        end else begin
            compare_result_q <= comparator_enable_q && raw_sync;
        end
    end

    // Rising flag: hardware set wins over a software write
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rising_edge_flag_q <= CEC_CTRL_RESET[CEC_BIT_RISE];
        end else if (rise_evt) begin
            rising_edge_flag_q <= 1'b1;
        end else if (wr_hit) begin
            rising_edge_flag_q <= reg_wdata_i[CEC_BIT_RISE];
        end
    end

    // Falling flag: hardware set wins over a software write
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            falling_edge_flag_q <= CEC_CTRL_RESET[CEC_BIT_FALL];
        end else if (fall_evt) begin
            falling_edge_flag_q <= 1'b1;
        end else if (wr_hit) begin
            falling_edge_flag_q <= reg_wdata_i[CEC_BIT_FALL];
        end
    end

    // Read data captured on a read strobe, zero otherwise
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= CEC_CTRL_RESET;
        end else if (rd_hit) begin
            rdata_q <= {comparator_enable_q, compare_result_q,
                        rising_edge_flag_q, falling_edge_flag_q,
                        pos_hys_q, negative_hysteresis_select_q};
        end else begin
            rdata_q <= '0;
        end
    end

    // Outputs to software and to the analog core
    assign reg_rdata_o = rdata_q;
    assign comparator_enable_o = comparator_enable_q;
    assign positive_hysteresis_select_o = pos_hys_q;
    assign negative_hysteresis_select_o = negative_hysteresis_select_q;

    // Checks
    // A write reaches the enable bit on the next edge
    property p_enable_write;
        @(posedge mclk_i) disable iff (!rst_n)
        wr_hit |=> comparator_enable_o == $past(reg_wdata_i[CEC_BIT_ENABLE]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable bit did not follow write");

    // Result follows the synchronised input while enabled
    property p_result_track;
        @(posedge mclk_i) disable iff (!rst_n)
        $past(comparator_enable_q) |-> compare_result_q == $past(raw_sync);
    endproperty
    a_result_track: assert property (p_result_track)
        else $error("result does not track compare input");

    // Steady high input reaches the result after three edges
    sequence s_enabled_high;
        (comparator_enable_q && raw_compare_i && !wr_hit)[*4];
    endsequence
    property p_sync_latency;
        @(posedge mclk_i) disable iff (!rst_n)
        s_enabled_high |-> compare_result_q;
    endproperty
    a_sync_latency: assert property (p_sync_latency)
        else $error("result latency wrong");

    // Disabled comparator reports 0 and raises no flag
    property p_disabled_quiet;
        @(posedge mclk_i) disable iff (!rst_n)
        !comparator_enable_q && !wr_hit
        |=> !compare_result_q && $stable(rising_edge_flag_q)
            && $stable(falling_edge_flag_q);
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled comparator changed state");

    // Rising edge sets the flag even against a clearing write
    sequence s_rise;
        comparator_enable_q && $rose(raw_sync);
    endsequence
    property p_rise_sets;
        @(posedge mclk_i) disable iff (!rst_n)
        s_rise |=> rising_edge_flag_q;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rising edge lost");

    // Falling edge sets the flag even against a clearing write
    sequence s_fall;
        comparator_enable_q && $fell(raw_sync);
    endsequence
    property p_fall_sets;
        @(posedge mclk_i) disable iff (!rst_n)
        s_fall |=> falling_edge_flag_q;
    endproperty
    a_fall_sets: assert property (p_fall_sets)
        else $error("falling edge lost");

    // Both flags, when set together, stay set until a software write
    property p_flags_sticky;
        @(posedge mclk_i) disable iff (!rst_n)
        rising_edge_flag_q && falling_edge_flag_q && !wr_hit
        |=> rising_edge_flag_q && falling_edge_flag_q;
    endproperty
    a_flags_sticky: assert property (p_flags_sticky)
        else $error("edge flag cleared by hardware");

    // The rising flag cannot appear without an edge or a write
    property p_flag_needs_cause;
        @(posedge mclk_i) disable iff (!rst_n)
        !rising_edge_flag_q && !rise_evt && !wr_hit |=> !rising_edge_flag_q;
    endproperty
    a_flag_needs_cause: assert property (p_flag_needs_cause)
        else $error("rising flag set without cause");

    // The falling flag likewise needs an edge or a write
    property p_fall_needs_cause;
        @(posedge mclk_i) disable iff (!rst_n)
        !falling_edge_flag_q && !fall_evt && !wr_hit
        |=> !falling_edge_flag_q;
    endproperty
    a_fall_needs_cause: assert property (p_fall_needs_cause)
        else $error("falling flag set without cause");

    // Positive field follows writes; negative field holds without a write
    property p_pos_hys;
        @(posedge mclk_i) disable iff (!rst_n)
        wr_hit |=> positive_hysteresis_select_o
            == $past(reg_wdata_i[CEC_POS_HYS_LSB +: CEC_HYS_W]);
    endproperty
    a_pos_hys: assert property (p_pos_hys)
        else $error("positive hysteresis not written");

    property p_neg_hys;
        @(posedge mclk_i) disable iff (!rst_n)
        !wr_hit |=> $stable(negative_hysteresis_select_o);
    endproperty
    a_neg_hys: assert property (p_neg_hys)
        else $error("negative hysteresis changed without write");

    // Negative hysteresis takes the written code on the next edge
    property p_neg_hys_write;
        @(posedge mclk_i) disable iff (!rst_n)
        wr_hit |=> negative_hysteresis_select_o
            == $past(reg_wdata_i[CEC_NEG_HYS_LSB +: CEC_HYS_W]);
    endproperty
    a_neg_hys_write: assert property (p_neg_hys_write)
        else $error("negative hysteresis not written");
endmodule

// File: bench/cec_analog_model.sv
// Behavioural analog comparator core on the far side of the block.
// Assumes the bench sets the input voltages in millivolts.
`timescale 1ns/1ps
module cec_analog_model (
    input wire logic mclk_i, // Clock used only to time output moves
    input wire logic enable_i, // Core enable from the block
    input wire logic [cec_pkg::CEC_HYS_W-1:0] pos_hys_i, // Positive hyst
    input wire logic [cec_pkg::CEC_HYS_W-1:0] neg_hys_i, // Negative hyst
    input wire logic signed [15:0] plus_mv_i, // Plus input voltage
    input wire logic signed [15:0] minus_mv_i, // Minus input voltage
    output logic raw_o = 1'b0 // Raw compare output
);
    import cec_pkg::*;

    // Hysteresis code to threshold offset in millivolts
    function automatic int hys_mv(input logic [CEC_HYS_W-1:0] c);
        case (c)
            CEC_HYS_5MV: return 5;
            CEC_HYS_10MV: return 10;
            CEC_HYS_20MV: return 20;
            default: return 0;
        endcase
    endfunction

    // Output moves off the sampling edge, like an unclocked core
    always @(negedge mclk_i) begin
        if (!enable_i) begin
            // A disabled core gives no valid level, so it toggles
            raw_o <= ~raw_o;
        end else if (plus_mv_i >= minus_mv_i + hys_mv(pos_hys_i)) begin
            raw_o <= 1'b1;
        end else if (plus_mv_i < minus_mv_i - hys_mv(neg_hys_i)) begin
            raw_o <= 1'b0;
        end
    end
endmodule

// File: bench/test_comparator_edge_control.sv
// Self-checking bench for the comparator edge-control block.
// Assumes the analog core model drives the raw compare input.
`timescale 1ns/1ps
module test_comparator_edge_control;
    import cec_pkg::*;

    localparam logic [7:0] EN = 8'h01 << CEC_BIT_ENABLE; // Enable bit
    localparam logic [7:0] RES = 8'h01 << CEC_BIT_RESULT; // Result bit
    localparam logic [7:0] RISE = 8'h01 << CEC_BIT_RISE; // Rising flag
    localparam logic [7:0] FALL = 8'h01 << CEC_BIT_FALL; // Falling flag

    logic mclk = 1'b0; // System clock
    logic resetn = 1'b0; // Reset, active low
    logic [7:0] addr = 8'h00; // Register address
    logic wr = 1'b0; // Write strobe
    logic rd = 1'b0; // Read strobe
    logic [7:0] wdata = 8'h00; // Write data
    logic [7:0] rdata; // Read data
    logic raw; // Raw compare from the model
    logic en_o; // Enable to the core
    logic [1:0] pos_o; // Positive hysteresis out
    logic [1:0] neg_o; // Negative hysteresis out
    logic signed [15:0] plus_mv = 16'sd0; // Plus input
    logic signed [15:0] minus_mv = 16'sd100; // Minus input
    int n_mismatch = 0; // Mismatches seen
    int cmp_count = 0; // Comparisons made
    int cyc = 0; // Cycle counter for the hang limit
    logic [7:0] v; // Loop register value

    always #12.5 mclk = ~mclk;

    cec_top dut (.mclk_i(mclk), .resetn_i(resetn), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .raw_compare_i(raw),
        .comparator_enable_o(en_o),
        .positive_hysteresis_select_o(pos_o),
        .negative_hysteresis_select_o(neg_o));

    cec_analog_model core (.mclk_i(mclk), .enable_i(en_o),
        .pos_hys_i(pos_o), .neg_hys_i(neg_o), .plus_mv_i(plus_mv),
        .minus_mv_i(minus_mv), .raw_o(raw));

    // Prints counts and verdict, then stops
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compares one value and reports a difference
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // One-cycle read strobe, data checked in the following cycle
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 check("reg_rdata_o", rdata, exp);
    endtask

    // Lets the compare path settle through its synchroniser
    task automatic settle();
        repeat (6) @(posedge mclk);
    endtask

    // Hang limit well above the expected run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_reg(CEC_CTRL_ADDR, CEC_CTRL_RESET);
        #1 check("enable", {7'h00, en_o}, 8'h00);
        settle();
        // Disabled core toggles: result stays 0 and no flag is set
        rd_reg(CEC_CTRL_ADDR, 8'h00);
        wr_reg(CEC_CTRL_ADDR, EN);
        #1 check("enable", {7'h00, en_o}, 8'h01);
        settle();
        wr_reg(CEC_CTRL_ADDR, EN);
        rd_reg(CEC_CTRL_ADDR, EN);
        plus_mv <= 16'sd150;
        settle();
        rd_reg(CEC_CTRL_ADDR, EN | RES | RISE);
        settle();
        rd_reg(CEC_CTRL_ADDR, EN | RES | RISE);
        wr_reg(CEC_CTRL_ADDR, EN);
        rd_reg(CEC_CTRL_ADDR, EN | RES);
        plus_mv <= 16'sd0;
        settle();
        rd_reg(CEC_CTRL_ADDR, EN | FALL);
        settle();
        rd_reg(CEC_CTRL_ADDR, EN | FALL);
        wr_reg(CEC_CTRL_ADDR, EN);
        rd_reg(CEC_CTRL_ADDR, EN);
        // Writing 1 to both flags sets them; they then hold
        wr_reg(CEC_CTRL_ADDR, EN | RISE | FALL);
        settle();
        rd_reg(CEC_CTRL_ADDR, EN | RISE | FALL);
        // Every hysteresis code in both fields
        for (int c = 0; c < 4; c++) begin
            v = EN | 8'(c << CEC_POS_HYS_LSB) | 8'(3 - c);
            wr_reg(CEC_CTRL_ADDR, v);
            #1 check("pos_hys", {6'h00, pos_o}, 8'(c));
            check("neg_hys", {6'h00, neg_o}, 8'(3 - c));
            rd_reg(CEC_CTRL_ADDR, v);
        end
        // Positive threshold 20 mV: 10 mV above minus is no edge
        plus_mv <= 16'sd110;
        settle();
        rd_reg(CEC_CTRL_ADDR, v);
        plus_mv <= 16'sd130;
        settle();
        rd_reg(CEC_CTRL_ADDR, v | RES | RISE);
        // Other address ignored and reads 0, result bit not writable
        wr_reg(8'hBE, 8'h00);
        rd_reg(8'hBE, 8'h00);
        rd_reg(CEC_CTRL_ADDR, v | RES | RISE);
        wr_reg(CEC_CTRL_ADDR, EN);
        rd_reg(CEC_CTRL_ADDR, EN | RES);
        // Disabling with the input high drops the result to 0
        wr_reg(CEC_CTRL_ADDR, RES);
        settle();
        rd_reg(CEC_CTRL_ADDR, 8'h00);
        #1 check("enable", {7'h00, en_o}, 8'h00);
        end_of_test();
    end
endmodule
